// file: t2cc_top.sv
/*
  Timer 2 counter, reload/compare and three input capture channels.
  Assumes a plain register port and capture pins asynchronous to clock.
*/
// The implementer's own choice: strobed register access.
// Operation
// [RULE1] Compare mode compares counter with reload bytes
// [RULE2] Reload mode loads reload bytes on overflow
// [RULE3] Counter is 16 bits, low and high bytes
// [RULE4] Counter bytes accessed separately, no latching
// [RULE5] Software halts counter before counter access
// [RULE6] Per-channel capture enable bits 6, 5, 4
// [RULE7] Edge sets capture flag; software clears it
// [RULE8] Edge select: fall, rise, either; 11 reserved
// [RULE9] Capture copies counter into result bytes
// [RULE10] Compare match sets overflow/match flag
// [RULE11] Mode bit: 0 reload, 1 compare
// [RULE12] Counter byte writes and reads act immediately
// [RULE13] Flags writable; hardware set beats clear
`timescale 1ns/100ps
`default_nettype none
module t2cc_top
  import t2cc_pkg::*;
#(
  parameter int NCH = T2CC_NCH
) (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [T2CC_AW-1:0] i_addr,
  input wire logic [T2CC_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [T2CC_DW-1:0] o_rdata,
  input wire logic [NCH-1:0] i_capture_pin,
  output logic [NCH-1:0] o_capture_event,
  output logic o_overflow_match_flag,
  output logic o_run_control_bit,
  output logic o_compare_reload_mode_select
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Capture edge detection
  // ----------------------------------------------------------------
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] edge_hit;
  logic [NCH-1:0] capture_enable;
  logic [NCH-1:0] capture_flag;
  logic [T2CC_DW-1:0] edge_select;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [1:0] sel;
      t2cc_edge u_edge (
        .i_clock(i_clock),
        .i_resetn(rst_n),
        .i_pin(i_capture_pin[g]),
        .o_rise(rise[g]),
        .o_fall(fall[g])
      );
      assign sel = edge_select[g*T2CC_EDGE_SEL_W +: T2CC_EDGE_SEL_W];
      // Selected edge of an enabled channel [RULE8] [RULE6]
      assign edge_hit[g] = capture_enable[g] &
        (((sel == T2CC_EDGE_FALL) & fall[g]) |
         ((sel == T2CC_EDGE_RISE) & rise[g]) |
         ((sel == T2CC_EDGE_BOTH) & (rise[g] | fall[g])));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic run;
  logic mode;
  logic ovf_flag;
  logic [T2CC_CW-1:0] rcmp;
  logic [T2CC_CW-1:0] cnt;
  logic [T2CC_CW-1:0] cap [NCH];
  logic [T2CC_DW-1:0] rdata;
  logic next_run;
  logic next_mode;
  logic next_ovf_flag;
  logic [NCH-1:0] next_capture_enable;
  logic [NCH-1:0] next_capture_flag;
  logic [T2CC_DW-1:0] next_edge_select;
  logic [T2CC_CW-1:0] next_rcmp;
  logic [T2CC_CW-1:0] next_cnt;
  logic [T2CC_CW-1:0] next_cap [NCH];
  logic [T2CC_DW-1:0] next_rdata;
  logic wr_ctrl;
  logic wr_cap;
  logic match;
  logic overflow;

  always_comb begin
    wr_ctrl = i_wr & (i_addr == T2CC_ADDR_CONTROL);
    wr_cap = i_wr & (i_addr == T2CC_ADDR_CAP_EN_FLAGS);
    match = run & (mode == T2CC_MODE_COMPARE) & (cnt == rcmp); // [RULE1]
    overflow = run & (cnt == T2CC_CNT_MAX);
    next_run = run;
    next_mode = mode;
    next_ovf_flag = ovf_flag;
    next_capture_enable = capture_enable;
    next_capture_flag = capture_flag;
    next_edge_select = edge_select;
    next_rcmp = rcmp;
    next_cnt = cnt;
    next_cap = cap;
    next_rdata = T2CC_RESET_BYTE;
    // Counting and reload
    if (run) begin
      if ((mode == T2CC_MODE_RELOAD) && overflow) begin
        next_cnt = rcmp; // [RULE2] [RULE11]
      end else begin
        next_cnt = cnt + T2CC_CNT_ONE;
      end
    end
    // Software writes
    if (wr_ctrl) begin
      next_run = i_wdata[T2CC_BIT_RUN];
      next_mode = i_wdata[T2CC_BIT_MODE];
      next_ovf_flag = i_wdata[T2CC_BIT_OVF_FLAG];
    end
    if (wr_cap) begin
      next_capture_enable = i_wdata[T2CC_BIT_CAP_EN0 +: NCH];
      next_capture_flag = i_wdata[T2CC_BIT_CAP_FLAG0 +: NCH]; // [RULE13]
    end
    if (i_wr && (i_addr == T2CC_ADDR_EDGE_SEL)) begin
      next_edge_select = {2'h0, i_wdata[5:0]};
    end
    if (i_wr && (i_addr == T2CC_ADDR_RCMP_LOW)) begin
      next_rcmp[7:0] = i_wdata;
    end
    if (i_wr && (i_addr == T2CC_ADDR_RCMP_HIGH)) begin
      next_rcmp[15:8] = i_wdata;
    end
    if (i_wr && (i_addr == T2CC_ADDR_CNT_LOW)) begin
      next_cnt[7:0] = i_wdata; // [RULE4] [RULE12] [RULE5]
    end
    if (i_wr && (i_addr == T2CC_ADDR_CNT_HIGH)) begin
      next_cnt[15:8] = i_wdata; // [RULE3] [RULE4] [RULE12]
    end
    // Hardware sets win over software clears
    if (match || ((mode == T2CC_MODE_RELOAD) && overflow)) begin
      next_ovf_flag = 1'b1; // [RULE10]
    end
    for (int i = 0; i < NCH; i++) begin
      if (edge_hit[i]) begin
        next_capture_flag[i] = 1'b1; // [RULE7]
        next_cap[i] = cnt; // [RULE9]
      end
    end
    // Read path
    if (i_rd) begin
      case (i_addr)
        T2CC_ADDR_CONTROL: begin
          next_rdata[T2CC_BIT_OVF_FLAG] = ovf_flag;
          next_rdata[T2CC_BIT_RUN] = run;
          next_rdata[T2CC_BIT_MODE] = mode;
        end
        T2CC_ADDR_CAP_EN_FLAGS: begin
          next_rdata[T2CC_BIT_CAP_EN0 +: NCH] = capture_enable;
          next_rdata[T2CC_BIT_CAP_FLAG0 +: NCH] = capture_flag;
        end
        T2CC_ADDR_EDGE_SEL: next_rdata = edge_select;
        T2CC_ADDR_RCMP_LOW: next_rdata = rcmp[7:0];
        T2CC_ADDR_RCMP_HIGH: next_rdata = rcmp[15:8];
        T2CC_ADDR_CNT_LOW: next_rdata = cnt[7:0]; // [RULE12]
        T2CC_ADDR_CNT_HIGH: next_rdata = cnt[15:8]; // [RULE3]
        T2CC_ADDR_CAP0_LOW: next_rdata = cap[0][7:0];
        T2CC_ADDR_CAP0_HIGH: next_rdata = cap[0][15:8];
        T2CC_ADDR_CAP1_LOW: next_rdata = cap[1][7:0];
        T2CC_ADDR_CAP1_HIGH: next_rdata = cap[1][15:8];
        T2CC_ADDR_CAP2_LOW: next_rdata = cap[2][7:0];
        T2CC_ADDR_CAP2_HIGH: next_rdata = cap[2][15:8];
        default: next_rdata = T2CC_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b0;
      mode <= T2CC_MODE_RELOAD;
      ovf_flag <= 1'b0;
      capture_enable <= '0;
      capture_flag <= '0;
      edge_select <= T2CC_RESET_BYTE;
      rcmp <= '0;
      cnt <= '0;
      for (int i = 0; i < NCH; i++) begin
        cap[i] <= '0;
      end
      rdata <= T2CC_RESET_BYTE;
    end else begin
      run <= next_run;
      mode <= next_mode;
      ovf_flag <= next_ovf_flag;
      capture_enable <= next_capture_enable;
      capture_flag <= next_capture_flag;
      edge_select <= next_edge_select;
      rcmp <= next_rcmp;
      cnt <= next_cnt;
      cap <= next_cap;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    o_rdata = rdata;
    o_capture_event = edge_hit;
    o_overflow_match_flag = ovf_flag;
    o_run_control_bit = run;
    o_compare_reload_mode_select = mode;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  sequence s_cmp_hit;
    run && mode && (cnt == rcmp);
  endsequence
  sequence s_wr_cnt_low;
    i_wr && (i_addr == T2CC_ADDR_CNT_LOW) && !run;
  endsequence

  property p_compare_flag;
    s_cmp_hit |=> ovf_flag;
  endproperty
  a_compare_flag: assert property (p_compare_flag) // [RULE10] [RULE1]
    else $error("compare match did not set flag");

  property p_reload;
    run && !mode && (cnt == T2CC_CNT_MAX) &&
      !(i_wr && (i_addr == T2CC_ADDR_CNT_LOW ||
                 i_addr == T2CC_ADDR_CNT_HIGH))
      |=> (cnt == $past(rcmp)) && ovf_flag;
  endproperty
  a_reload: assert property (p_reload) // [RULE2]
    else $error("overflow did not reload counter");

  property p_cnt_low_write;
    s_wr_cnt_low ##1 (i_rd && (i_addr == T2CC_ADDR_CNT_LOW))
      |=> (o_rdata == $past(i_wdata, 2)) && (cnt[15:8] == $past(cnt[15:8], 2));
  endproperty
  a_cnt_low_write: assert property (p_cnt_low_write) // [RULE4] [RULE12]
    else $error("counter low write not seen or high byte changed");

  property p_cnt_high_read;
    i_rd && (i_addr == T2CC_ADDR_CNT_HIGH) |=> o_rdata == $past(cnt[15:8]);
  endproperty
  a_cnt_high_read: assert property (p_cnt_high_read) // [RULE3]
    else $error("counter high read wrong");

  property p_cnt_high_write;
    i_wr && (i_addr == T2CC_ADDR_CNT_HIGH) |=> cnt[15:8] == $past(i_wdata);
  endproperty
  a_cnt_high_write: assert property (p_cnt_high_write) // [RULE12] [RULE4]
    else $error("counter high write not applied");

  property p_cap_flag(int ch);
    edge_hit[ch] |=> capture_flag[ch] && (cap[ch] == $past(cnt));
  endproperty
  a_cap_flag0: assert property (p_cap_flag(0)) // [RULE7] [RULE9] [RULE13]
    else $error("capture 0 flag or value wrong");
  a_cap_flag1: assert property (p_cap_flag(1)) // [RULE7] [RULE9]
    else $error("capture 1 flag or value wrong");
  a_cap_flag2: assert property (p_cap_flag(2)) // [RULE7] [RULE9]
    else $error("capture 2 flag or value wrong");

  property p_cap_disabled;
    !capture_enable[1] && !wr_cap |=> $stable(capture_flag[1]) &&
      $stable(cap[1]);
  endproperty
  a_cap_disabled: assert property (p_cap_disabled) // [RULE6]
    else $error("disabled channel produced an event");

  property p_edge_rise_only;
    capture_enable[0] && (edge_select[1:0] == T2CC_EDGE_RISE) && fall[0]
      |-> !edge_hit[0];
  endproperty
  a_edge_rise_only: assert property (p_edge_rise_only) // [RULE8]
    else $error("rising select fired on falling edge");

  property p_reload_no_match;
    run && !mode && (cnt != T2CC_CNT_MAX) && !ovf_flag && !wr_ctrl
      |=> !ovf_flag;
  endproperty
  a_reload_no_match: assert property (p_reload_no_match) // [RULE11]
    else $error("flag set in reload mode without overflow");
endmodule
`default_nettype wire

// file: t2cc_pkg.sv
/*
  Constants for the timer 2 capture/compare register block.
  Assumes an 8-bit register address space and 8-bit registers.
*/
`default_nettype none
package t2cc_pkg;
  localparam int T2CC_AW = 8;
  localparam int T2CC_DW = 8;
  localparam int T2CC_CW = 16;
  localparam int T2CC_NCH = 3;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] T2CC_ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] T2CC_ADDR_CAP_EN_FLAGS = 8'h92;
  localparam logic [7:0] T2CC_ADDR_EDGE_SEL = 8'h93;
  localparam logic [7:0] T2CC_ADDR_RCMP_LOW = 8'hca;
  localparam logic [7:0] T2CC_ADDR_RCMP_HIGH = 8'hcb;
  localparam logic [7:0] T2CC_ADDR_CNT_LOW = 8'hcc;
  localparam logic [7:0] T2CC_ADDR_CNT_HIGH = 8'hcd;
  localparam logic [7:0] T2CC_ADDR_CAP0_LOW = 8'he4;
  localparam logic [7:0] T2CC_ADDR_CAP0_HIGH = 8'he5;
  localparam logic [7:0] T2CC_ADDR_CAP1_LOW = 8'he6;
  localparam logic [7:0] T2CC_ADDR_CAP1_HIGH = 8'he7;
  localparam logic [7:0] T2CC_ADDR_CAP2_LOW = 8'hed;
  localparam logic [7:0] T2CC_ADDR_CAP2_HIGH = 8'hee;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int T2CC_BIT_OVF_FLAG = 7;
  localparam int T2CC_BIT_RUN = 2;
  localparam int T2CC_BIT_MODE = 0;
  localparam int T2CC_BIT_CAP_EN0 = 4;
  localparam int T2CC_BIT_CAP_FLAG0 = 0;
  localparam int T2CC_EDGE_SEL_W = 2;
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] T2CC_RESET_BYTE = 8'h00;
  localparam logic [15:0] T2CC_CNT_MAX = 16'hffff;
  localparam logic [15:0] T2CC_CNT_ONE = 16'h0001;
  localparam logic T2CC_MODE_RELOAD = 1'b0;
  localparam logic T2CC_MODE_COMPARE = 1'b1;
  localparam logic [1:0] T2CC_EDGE_FALL = 2'h0;
  localparam logic [1:0] T2CC_EDGE_RISE = 2'h1;
  localparam logic [1:0] T2CC_EDGE_BOTH = 2'h2;
endpackage
`default_nettype wire

// file: t2cc_edge.sv
/*
  Pin synchroniser and edge detector for one capture input.
  Assumes i_pin is asynchronous to i_clock.
*/
`timescale 1ns/100ps
`default_nettype none
module t2cc_edge (
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic sync1;
  logic sync2;
  logic sync3;
  // ----------------------------------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  always_comb begin
    o_rise = sync2 & ~sync3;
    o_fall = ~sync2 & sync3;
  end
endmodule
`default_nettype wire

// file: t2cc_pin_model.sv
/*
  Far-side model: the three capture pins.
  Assumes the bench calls toggle right after a clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module t2cc_pin_model (
  input wire logic i_clock,
  output logic [2:0] o_pin
);
  initial o_pin = 3'h0;
  // ----------------------------------------
  // Pin stimulus
  // ----------------------------------------
  // One pin changes per call, just after an edge
  task automatic toggle(input int ch);
    @(posedge i_clock);
    o_pin[ch] <= ~o_pin[ch];
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench for the timer 2 capture/compare block.
  Assumes the register port and pin model described beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import t2cc_pkg::*;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [2:0] pins;
  logic [2:0] ev;
  logic ovf;
  logic run;
  logic mode;
  logic [7:0] ev_cnt [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] regs [4] = '{T2CC_ADDR_CAP_EN_FLAGS, T2CC_ADDR_EDGE_SEL,
    T2CC_ADDR_RCMP_LOW, T2CC_ADDR_RCMP_HIGH};
  logic [7:0] masks [4] = '{8'h77, 8'h3f, 8'hff, 8'hff};
  logic [7:0] res_lo [3] = '{T2CC_ADDR_CAP0_LOW, T2CC_ADDR_CAP1_LOW,
    T2CC_ADDR_CAP2_LOW};
  logic [7:0] res_hi [3] = '{T2CC_ADDR_CAP0_HIGH, T2CC_ADDR_CAP1_HIGH,
    T2CC_ADDR_CAP2_HIGH};
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 55;
  always #25 i_clock = ~i_clock;
  t2cc_top u_t2cc_top (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_capture_pin(pins), .o_capture_event(ev),
    .o_overflow_match_flag(ovf), .o_run_control_bit(run),
    .o_compare_reload_mode_select(mode));
  t2cc_pin_model u_t2cc_pin_model (.i_clock(i_clock), .o_pin(pins));
  always @(posedge i_clock) begin
    for (int i = 0; i < 3; i++) begin
      if (ev[i] === 1'b1) begin
        ev_cnt[i] <= ev_cnt[i] + 8'h01;
      end
    end
  end
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    logic [7:0] d;
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_clock);
    chk(nm, e, d);
  endtask
  task automatic wrchk(input string nm, input logic [7:0] a,
    input logic [7:0] wd);
    logic [7:0] q;
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= wd;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
    @(posedge i_clock);
    chk(nm, wd, q);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic set_cnt(input logic [15:0] c);
    wr(T2CC_ADDR_CNT_LOW, c[7:0]);
    wr(T2CC_ADDR_CNT_HIGH, c[15:8]);
  endtask
  initial begin
    repeat (6000) @(posedge i_clock);
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] n0;
    logic [15:0] v;
    logic [1:0] code;
    logic en;
    logic hit;
    int ch;
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clock);
    foreach (regs[i]) rchk("reset", regs[i], 8'h00);
    rchk("reset cnt", T2CC_ADDR_CNT_LOW, 8'h00);
    foreach (regs[i]) begin
      d = 8'($random(seed));
      wr(regs[i], d);
      rchk("reg rw", regs[i], d & masks[i]);
    end
    wr(8'h00, 8'hff);
    rchk("unmapped", 8'h00, 8'h00);
    $display("register test done");
    v = 16'($random(seed));
    set_cnt(v);
    wrchk("cnt low", T2CC_ADDR_CNT_LOW, ~v[7:0]);
    rchk("cnt high", T2CC_ADDR_CNT_HIGH, v[15:8]);
    $display("counter test done");
    for (int k = 0; k < 2; k++) begin
      v = {8'h40 | 8'($random(seed)), 8'($random(seed))};
      wr(T2CC_ADDR_RCMP_LOW, v[7:0]);
      wr(T2CC_ADDR_RCMP_HIGH, v[15:8]);
      set_cnt(k ? v + 16'h0001 : v - 16'h000a);
      wr(T2CC_ADDR_CONTROL, 8'h05);
      repeat (20) @(posedge i_clock);
      rchk("cmp ctrl", T2CC_ADDR_CONTROL, k ? 8'h05 : 8'h85);
      chk_bit("cmp flag", k == 0, ovf);
      chk_bit("run bit", 1'b1, run);
      chk_bit("cmp mode", 1'b1, mode);
      wr(T2CC_ADDR_CONTROL, 8'h00);
    end
    $display("compare test done");
    v = {8'($random(seed)), 8'($random(seed)) & 8'h7f};
    wr(T2CC_ADDR_RCMP_LOW, v[7:0]);
    wr(T2CC_ADDR_RCMP_HIGH, v[15:8]);
    set_cnt(16'hfffa);
    wr(T2CC_ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge i_clock);
    rchk("reload flag", T2CC_ADDR_CONTROL, 8'h84);
    chk_bit("reload mode", 1'b0, mode);
    wr(T2CC_ADDR_CONTROL, 8'h00);
    rchk("reload high", T2CC_ADDR_CNT_HIGH, v[15:8]);
    $display("reload test done");
    for (int t = 0; t < 12; t++) begin
      ch = t % 3;
      code = (t < 3) ? 2'(t) : 2'({$random(seed)} % 3);
      en = (t != 4);
      v = 16'($random(seed));
      set_cnt(v);
      wr(T2CC_ADDR_EDGE_SEL, 8'(code) << (2 * ch));
      wr(T2CC_ADDR_CAP_EN_FLAGS, 8'(en) << (4 + ch));
      hit = en && (code == 2'h2 || (code == 2'h1 && !pins[ch])
        || (code == 2'h0 && pins[ch]));
      n0 = ev_cnt[ch];
      u_t2cc_pin_model.toggle(ch);
      repeat (6) @(posedge i_clock);
      chk("events", n0 + 8'(hit), ev_cnt[ch]);
      rchk("flags", T2CC_ADDR_CAP_EN_FLAGS,
        (8'(en) << (4 + ch)) | (8'(hit) << ch));
      if (hit) begin
        rchk("res low", res_lo[ch], v[7:0]);
        rchk("res high", res_hi[ch], v[15:8]);
      end
      wr(T2CC_ADDR_CAP_EN_FLAGS, 8'h00);
      rchk("flag clr", T2CC_ADDR_CAP_EN_FLAGS, 8'h00);
    end
    $display("capture test done");
    summarize();
  end
endmodule
`default_nettype wire
